// [testbench/dlcirq_checker.sv]
// Purpose: bus and event timing checks on the mask bank ports
// Assumes: hready tied to hreadyout, one clock domain
// Notes: bound to dlcirq_top, watches ports only
`timescale 1ns/1ns
`default_nettype none
module dlcirq_checker
  import dlcirq_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire dlcirq_pkg::dlcirq_lvl_t status_levels,
  input wire dlcirq_pkg::dlcirq_evt_t status_pulses,
  input wire dlcirq_pkg::dlcirq_irq_t irq_events_q,
  input wire logic irq_q
);
  logic wr_tk;
  logic rd_tk;
  assign wr_tk = hsel && htrans[1] && hready && hwrite;
  assign rd_tk = hsel && htrans[1] && hready && !hwrite;
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  a_write_no_wait: assert property (wr_tk |=> hreadyout)
    else $error("write not answered at once");
  a_read_one_wait: assert property (rd_tk |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_resp_okay: assert property (!hresp)
    else $error("response not okay");
  a_hi_zero: assert property (hrdata[31:8] == 24'h000000)
    else $error("upper read data not zero");
  a_rsvd_quiet: assert property (!irq_events_q.state[1] &&
    irq_events_q.fast[7:5] == 3'h0 && irq_events_q.fast[1:0] == 2'h0 &&
    irq_events_q.prof[7:6] == 2'h0 && irq_events_q.analog_loop_irq_enable[7:5] == 3'h0)
    else $error("reserved event bit raised");
  a_irq_or: assert property (irq_q == |irq_events_q)
    else $error("irq not the or of events");
  a_freq_gain: assert property (irq_events_q.lock[2] |->
    $past(status_levels.freq_lock) && !$past(status_levels.freq_lock, 2))
    else $error("freq gain without rise");
  a_freq_loss: assert property (irq_events_q.lock[3] |->
    !$past(status_levels.freq_lock) && $past(status_levels.freq_lock, 2))
    else $error("freq loss without fall");
  a_phase_gain: assert property (irq_events_q.lock[0] |->
    $past(status_levels.phase_lock) && !$past(status_levels.phase_lock, 2))
    else $error("phase gain without rise");
  a_ref_switch: assert property (irq_events_q.state[7] |-> $past(status_pulses.ref_switch))
    else $error("ref switch irq without pulse");
  c_read: cover property (rd_tk);
  c_write: cover property (wr_tk);
  c_irq: cover property (irq_q);
endmodule // dlcirq_checker
bind dlcirq_top dlcirq_checker i_dlcirq_checker (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
  .hresp(hresp), .status_levels(status_levels), .status_pulses(status_pulses),
  .irq_events_q(irq_events_q), .irq_q(irq_q));
`default_nettype wire

// [testbench/dlcirq_top_bench.sv]
// Purpose: self-checking bench for the mask bank
// Assumes: single ahb master, hready fed back from hreadyout
// Notes: expected values come from the mask and bit tables here
`timescale 1ns/1ns
`default_nettype none
module dlcirq_top_bench;
  import dlcirq_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic [31:0] hrdata;
  dlcirq_lvl_t lvl = '0;
  dlcirq_evt_t evt = '0;
  dlcirq_irq_t irq_ev;
  logic irq;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;
  dlcirq_top i_dlcirq_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(), .status_levels(lvl),
    .status_pulses(evt), .irq_events_q(irq_ev), .irq_q(irq));
  always #50 hclk = ~hclk;
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // hang guard, the whole run needs well under 1000 cycles
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      error_cnt++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // hready sampled at negedge: inputs only move at posedge, so it equals the edge value
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    logic rdy;
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do
    begin
      @(negedge hclk);
      rdy = hreadyout;
      @(posedge hclk);
    end while (rdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do
    begin
      @(negedge hclk);
      rdy = hreadyout;
      r = hrdata;
      @(posedge hclk);
    end while (rdy !== 1'b1);
    hsel <= 1'b0;
  endtask
  logic [31:0] addr_t [6] = '{32'h444, 32'h448, 32'h44c, 32'h450, 32'h454, 32'h460};
  logic [7:0] wm_t [6] = '{8'hff, 8'hfd, 8'h1c, 8'h3f, 8'h1f, 8'h00};
  task automatic t_regs();
    logic [31:0] r;
    for (int i = 0; i < 6; i++)
    begin
      xfer(1'b0, addr_t[i], 32'h0, r);
      chk("reset value", {8'h0, r}, 40'h0);
      xfer(1'b1, addr_t[i], 32'hffffffff, r);
      xfer(1'b0, addr_t[i], 32'h0, r);
      chk("writable", {8'h0, r}, {32'h0, wm_t[i]});
    end
    $display("test regs done");
  endtask
  // one step of the levels, then the steady cycle after it
  task automatic step(input string nm, input logic [39:0] exp);
    @(posedge hclk);
    @(negedge hclk);
    chk(nm, irq_ev, exp);
    chk("irq line", {39'h0, irq}, {39'h0, |exp});
    @(negedge hclk);
    chk("steady level", irq_ev, 40'h0);
  endtask
  logic [5:0] lv_t [5] = '{6'h01, 6'h03, 6'h0f, 6'h3f, 6'h00};
  logic [39:0] le_t [5] = '{40'h0100000000, 40'h0400000000, 40'h5000000000,
                            40'h0010000004, 40'haa08000008};
  task automatic t_levels(input logic on);
    logic [31:0] r;
    for (int i = 0; i < 5; i++)
    begin
      @(posedge hclk);
      lvl <= lv_t[i];
      step("level", on ? le_t[i] : 40'h0);
      if (i == 3)
      begin
        xfer(1'b0, 32'h7c0, 32'h0, r);
        chk("status word", {8'h0, r}, 40'h3f);
      end
    end
    $display("test levels done");
  endtask
  int pos_t [17] = '{0, 1, 4, 8, 9, 10, 11, 12, 13, 18, 19, 20, 24, 26, 29, 30, 31};
  task automatic t_pulses(input logic on);
    logic [39:0] all;
    logic [39:0] exp_p;
    all = '0;
    for (int i = 0; i < 17; i++)
    begin
      all[pos_t[i]] = on;
      @(posedge hclk);
      evt <= dlcirq_evt_t'(17'h1 << i);
      @(posedge hclk);
      evt <= '0;
      @(negedge hclk);
      exp_p = on ? 40'h1 << pos_t[i] : 40'h0;
      chk("pulse", irq_ev, exp_p);
    end
    @(posedge hclk);
    evt <= '1;
    @(posedge hclk);
    evt <= '0;
    @(negedge hclk);
    chk("all", irq_ev, all);
    $display("test pulses done");
  endtask
  initial
  begin
    logic [31:0] r;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_levels(1'b1);
    t_pulses(1'b1);
    for (int i = 0; i < 5; i++)
      xfer(1'b1, addr_t[i], 32'h0, r);
    t_levels(1'b0);
    t_pulses(1'b0);
    end_sim();
  end
endmodule // dlcirq_top_bench
`default_nettype wire

// [verilog/dlcirq_ahb_slave.sv]
// Purpose: ahb-lite slave front end for the mask bank
// Assumes: single word transfers, one slave on the bus
// Notes: writes zero wait, reads one wait state, always okay
`timescale 1ns/1ns
`default_nettype none
module dlcirq_ahb_slave
  import dlcirq_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic [7:0] rdata,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output dlcirq_pkg::dlcirq_wr_t wr,
  output logic [11:0] idx_q
);
  import dlcirq_pkg::*;
  logic acc;
  logic wr_pend_q;
  logic rd_pend_q;
  logic rd_done_q;

  // hsize is not checked: only whole words are issued
  assign acc = hsel & htrans[1] & hready;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      idx_q <= 12'h000;
    end
    else if (hready)
    begin
      wr_pend_q <= acc & hwrite;
      rd_pend_q <= acc & ~hwrite;
      if (acc)
      begin
        idx_q <= dlcirq_idx(haddr);
      end
    end
  end

  // the wait cycle lets a read see a write just before it
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rd_done_q <= 1'b0;
      hrdata <= 32'h0000_0000;
    end
    else
    begin
      rd_done_q <= rd_pend_q & ~rd_done_q;
      if (rd_pend_q & ~rd_done_q)
      begin
        hrdata <= {24'h00_0000, rdata};
      end
    end
  end

  assign hreadyout = ~(rd_pend_q & ~rd_done_q);
  assign hresp = 1'b0;
  assign wr.en = wr_pend_q;
  assign wr.idx = idx_q;
  assign wr.data = hwdata[7:0];
endmodule // dlcirq_ahb_slave
`default_nettype wire

// [verilog/dlcirq_edge_detect.sv]
// Purpose: rise and fall pulses of the level status inputs
// Assumes: levels synchronous to hclk
// Notes: history starts low, so a level high at reset exit gives a rise
`timescale 1ns/1ns
`default_nettype none
module dlcirq_edge_detect
  import dlcirq_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire dlcirq_pkg::dlcirq_lvl_t lvl,
  output dlcirq_pkg::dlcirq_lvl_t lvl_q,
  output dlcirq_pkg::dlcirq_lvl_t rise,
  output dlcirq_pkg::dlcirq_lvl_t fall
);
  import dlcirq_pkg::*;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      lvl_q <= '0;
    end
    else
    begin
      lvl_q <= lvl;
    end
  end

  // steady levels give no pulse
  assign rise = lvl & ~lvl_q;
  assign fall = ~lvl & lvl_q;
endmodule // dlcirq_edge_detect
`default_nettype wire

// [verilog/dlcirq_pkg.sv]
// Purpose: constants and types of the loop channel zero irq mask bank
// Assumes: ahb-lite word access, one 8-bit register per word
// Notes: register byte address is four times its index
// Behaviour
// - lock bit 3 enables irq on frequency lock lost
// - lock bit 2 enables irq on frequency lock gained
// - lock bit 1 enables irq on phase lock lost
// - lock bit 0 enables irq on phase lock gained
// - state bit 7 enables irq on reference switch
// - state bit 6 enables irq on freerun entry
// - state bit 5 enables irq on holdover entry
// - state bit 4 enables irq on hitless entry
// - state bit 3 enables irq on hitless exit
// - state bit 2 enables irq on holdover history update
// - state bit 0 enables irq on phase step; bit 1 reserved read-only
// - fast acquisition bit 4 enables irq on feedback divider resync
// - fast acquisition bit 3 enables irq on acquisition complete
// - fast acquisition bit 2 enables irq on acquisition start; bits 7:5 reserved
// - profile bit n enables irq when profile n activates; bits 7:6 reserved
// - analog bit 4 enables irq on distribution synced; bits 7:5 reserved
// - analog bit 3 enables irq on analog loop lock lost
// - analog bit 2 enables irq on analog loop lock gained
// - analog bit 1 enables irq on calibration complete
// - analog bit 0 enables irq on calibration start
// - lock bits 7..4 enable clamp off, clamp on, slew off, slew on
package dlcirq_pkg;
  localparam logic [11:0] LOCK_IDX = 12'h111;
  localparam logic [11:0] STATE_IDX = 12'h112;
  localparam logic [11:0] FAST_IDX = 12'h113;
  localparam logic [11:0] PROF_IDX = 12'h114;
  localparam logic [11:0] ANALOG_LOOP_IRQ_ENABLE_IDX = 12'h115;
  localparam logic [11:0] STATUS_IDX = 12'h1f0;
  localparam logic [7:0] LOCK_WMASK = 8'hff;
  localparam logic [7:0] STATE_WMASK = 8'hfd;
  localparam logic [7:0] FAST_WMASK = 8'h1c;
  localparam logic [7:0] PROF_WMASK = 8'h3f;
  localparam logic [7:0] ANALOG_LOOP_IRQ_ENABLE_WMASK = 8'h1f;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam int LVL_W = 6;

  // level status inputs, one bit each
  typedef struct packed {
    logic analog_lock;
    logic hitless;
    logic slew_limit;
    logic freq_clamp;
    logic freq_lock;
    logic phase_lock;
  } dlcirq_lvl_t;

  // one-cycle event pulses from the channel
  typedef struct packed {
    logic ref_switch;
    logic freerun;
    logic holdover;
    logic history;
    logic phase_step;
    logic ndiv_resync;
    logic fa_done;
    logic fa_start;
    logic [5:0] profile;
    logic dist_sync;
    logic cal_done;
    logic cal_start;
  } dlcirq_evt_t;

  // masked events, aligned with the mask register bits
  typedef struct packed {
    logic [7:0] lock;
    logic [7:0] state;
    logic [7:0] fast;
    logic [7:0] prof;
    logic [7:0] analog_loop_irq_enable;
  } dlcirq_irq_t;

  // register write from the bus slave
  typedef struct packed {
    logic en;
    logic [11:0] idx;
    logic [7:0] data;
  } dlcirq_wr_t;

  function automatic logic [11:0] dlcirq_idx(input logic [31:0] a);
    return a[13:2];
  endfunction

  function automatic logic [7:0] dlcirq_upd(input logic [7:0] old, input logic [7:0] wd,
                                            input logic [7:0] wm);
    return (old & ~wm) | (wd & wm);
  endfunction
endpackage

// [verilog/dlcirq_top.sv]
// Purpose: irq enable bank of loop channel zero, ahb-lite registers
// Assumes: status levels and event pulses synchronous to hclk
// Notes: irq_q is the registered or of the enabled events, one cycle late
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module dlcirq_top
  import dlcirq_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire dlcirq_pkg::dlcirq_lvl_t status_levels,
  input wire dlcirq_pkg::dlcirq_evt_t status_pulses,
  output dlcirq_pkg::dlcirq_irq_t irq_events_q,
  output logic irq_q
);
  import dlcirq_pkg::*;

  dlcirq_wr_t wr;
  logic [11:0] rd_idx;
  logic [7:0] rdata;
  logic [7:0] lock_q;
  logic [7:0] state_q;
  logic [7:0] fast_q;
  logic [7:0] prof_q;
  logic [7:0] analog_loop_irq_enable_q;
  dlcirq_lvl_t lvl_q;
  dlcirq_lvl_t rise;
  dlcirq_lvl_t fall;
  logic [7:0] lock_raw;
  logic [7:0] state_raw;
  logic [7:0] fast_raw;
  logic [7:0] prof_raw;
  logic [7:0] analog_loop_irq_enable_raw;
  dlcirq_irq_t masked;

  dlcirq_ahb_slave i_dlcirq_ahb_slave
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hready),
    .hwdata(hwdata),
    .rdata(rdata),
    .hreadyout(hreadyout),
    .hrdata(hrdata),
    .hresp(hresp),
    .wr(wr),
    .idx_q(rd_idx)
  );

  dlcirq_edge_detect i_dlcirq_edge_detect
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .lvl(status_levels),
    .lvl_q(lvl_q),
    .rise(rise),
    .fall(fall)
  );

  // mask registers; reserved bits are never stored
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      lock_q <= MASK_RST;
    end
    else if (wr.en && wr.idx == LOCK_IDX)
    begin
      lock_q <= dlcirq_upd(lock_q, wr.data, LOCK_WMASK);
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q <= MASK_RST;
    end
    else if (wr.en && wr.idx == STATE_IDX)
    begin
      state_q <= dlcirq_upd(state_q, wr.data, STATE_WMASK);
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      fast_q <= MASK_RST;
    end
    else if (wr.en && wr.idx == FAST_IDX)
    begin
      fast_q <= dlcirq_upd(fast_q, wr.data, FAST_WMASK);
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      prof_q <= MASK_RST;
    end
    else if (wr.en && wr.idx == PROF_IDX)
    begin
      prof_q <= dlcirq_upd(prof_q, wr.data, PROF_WMASK);
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      analog_loop_irq_enable_q <= MASK_RST;
    end
    else if (wr.en && wr.idx == ANALOG_LOOP_IRQ_ENABLE_IDX)
    begin
      analog_loop_irq_enable_q <= dlcirq_upd(analog_loop_irq_enable_q, wr.data, ANALOG_LOOP_IRQ_ENABLE_WMASK);
    end
  end

  // read mux; unmapped words read zero
  always_comb
  begin
    case (rd_idx)
      LOCK_IDX:
      begin
        rdata = lock_q;
      end
      STATE_IDX:
      begin
        rdata = state_q;
      end
      FAST_IDX:
      begin
        rdata = fast_q;
      end
      PROF_IDX:
      begin
        rdata = prof_q;
      end
      ANALOG_LOOP_IRQ_ENABLE_IDX:
      begin
        rdata = analog_loop_irq_enable_q;
      end
      STATUS_IDX:
      begin
        rdata = {irq_q, 1'b0, lvl_q};
      end
      default:
      begin
        rdata = 8'h00;
      end
    endcase
  end

  // lock group: edges of lock, clamp and slew levels
  always_comb
  begin
    lock_raw = 8'h00;
    lock_raw[7] = fall.freq_clamp;
    lock_raw[6] = rise.freq_clamp;
    lock_raw[5] = fall.slew_limit;
    lock_raw[4] = rise.slew_limit;
    lock_raw[3] = fall.freq_lock;
    lock_raw[2] = rise.freq_lock;
    lock_raw[1] = fall.phase_lock;
    lock_raw[0] = rise.phase_lock;
  end

  // state group; bit 1 has no source
  always_comb
  begin
    state_raw = 8'h00;
    state_raw[7] = status_pulses.ref_switch;
    state_raw[6] = status_pulses.freerun;
    state_raw[5] = status_pulses.holdover;
    state_raw[4] = rise.hitless;
    state_raw[3] = fall.hitless;
    state_raw[2] = status_pulses.history;
    state_raw[0] = status_pulses.phase_step;
  end

  // fast acquisition group
  always_comb
  begin
    fast_raw = 8'h00;
    fast_raw[4] = status_pulses.ndiv_resync;
    fast_raw[3] = status_pulses.fa_done;
    fast_raw[2] = status_pulses.fa_start;
  end

  // active profile group, one bit per profile
  always_comb
  begin
    prof_raw = 8'h00;
    prof_raw[5:0] = status_pulses.profile;
  end

  // analog loop group
  always_comb
  begin
    analog_loop_irq_enable_raw = 8'h00;
    analog_loop_irq_enable_raw[4] = status_pulses.dist_sync;
    analog_loop_irq_enable_raw[3] = fall.analog_lock;
    analog_loop_irq_enable_raw[2] = rise.analog_lock;
    analog_loop_irq_enable_raw[1] = status_pulses.cal_done;
    analog_loop_irq_enable_raw[0] = status_pulses.cal_start;
  end

  // gating; an event can fire the cycle after its enable is written
  always_comb
  begin
    masked.lock = lock_raw & lock_q;
    masked.state = state_raw & state_q;
    masked.fast = fast_raw & fast_q;
    masked.prof = prof_raw & prof_q;
    masked.analog_loop_irq_enable = analog_loop_irq_enable_raw & analog_loop_irq_enable_q;
  end

  // registered event vector keeps the output free of bus glitches
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq_events_q <= '0;
    end
    else
    begin
      irq_events_q <= masked;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= |masked;
    end
  end
endmodule // dlcirq_top
`default_nettype wire
